// *** design/dmds_map.vh ***
// register map, codes and defaults of the microdiagnostic sequencer
// Notes on behaviour
// [RQ1] offset read steps 25 uin, stops
// [RQ2] offset read options: once, continuous, loop
// [RQ3] operator loads cylinder and head bytes
// [RQ4] pattern byte 03, default db
// [RQ5] cylinder limited to 032e or 019a
// [RQ6] repeated read 65535 times, monitors errors
// [RQ7] byte 04 gives read offset, 775 max
// [RQ8] safety test sets, resets, checks latches
// [RQ9] offset test checks on-track drops
// [RQ10] index period measured on track, offset
// [RQ11] output byte display, pointer advances, wraps
// [RQ12] output byte 00 bit layout
// [RQ13] output byte 01 bit layout
// [RQ14] output byte 02 bit layout
// [RQ15] output byte 04 bit layout
// [RQ16] output byte 05 bit layout
// [RQ17] output byte 06 bit layout
// [RQ18] recalibrate returns to cylinder zero
// [RQ19] write head option: all or single
// [RQ20] write options: once, continuous, loop
// [RQ21] parameter pointer advances, resets on routine
// [RQ22] error code latched, loop repeats operation
`ifndef DMDS_MAP_VH
`define DMDS_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DMDS_CTRL 12'h000
`define DMDS_ROUT 12'h004
`define DMDS_PPTR 12'h008
`define DMDS_PDATA 12'h00c
`define DMDS_ECTL 12'h010
`define DMDS_STAT 12'h014
`define DMDS_ERR 12'h018
`define DMDS_DISP 12'h01c
`define DMDS_PERIOD 12'h020
`define DMDS_CFG 12'h024
// ----------------------------------------
// routine numbers and options
// ----------------------------------------
`define DMDS_R_OFFRD 8'h09
`define DMDS_R_READ 8'h0a
`define DMDS_R_SAFE 8'h0b
`define DMDS_R_OFFS 8'h0d
`define DMDS_R_INDEX 8'h10
`define DMDS_R_DISP 8'h11
`define DMDS_R_RECAL 8'h12
`define DMDS_R_WRITE 8'h13
`define DMDS_EC_ONCE 8'h00
`define DMDS_EC_CONT 8'h01
`define DMDS_EC_LOOP 8'h02
`define DMDS_EC_LINK 8'h80
`define DMDS_PAT_DEF 8'hdb
`define DMDS_OFF_STEP 10'h019
`define DMDS_OFF_END 10'h12c
`define DMDS_OFF_MAX 10'h307
`define DMDS_CYL_BIG 10'h32e
`define DMDS_CYL_SMALL 10'h19a
`define DMDS_READS 16'hffff
`define DMDS_NHEADS 8'h12
`define DMDS_NOUT 3'h7
// error codes
`define DMDS_E_NONE 8'h00
`define DMDS_E_UNSAFE 8'h01
`define DMDS_E_CMP 8'h02
`define DMDS_E_LATCH 8'h03
`define DMDS_E_ONTRK 8'h04
`define DMDS_E_INDEX 8'h05
`define DMDS_E_RECAL 8'h06
`define DMDS_E_WRITE 8'h07
`define DMDS_E_CYL 8'h08
`define DMDS_E_RDERR 8'h09
`endif

// *** design/dmds_seq.v ***
// microdiagnostic sequencer: apb registers, routine engine, output byte display
//
// Implementation choices: the APB interface to the registers and the placing of the registers.

`timescale 1ns/100ps
`include "dmds_map.vh"

module dmds_seq #(
    parameter IDX_TIMEOUT = 32'd5000000
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,

    // drive status lines, asynchronous
    input wire [55:0] drive_lines,
    input wire index_pulse,
    input wire on_track,
    input wire op_done,
    input wire op_error,
    input wire cmp_ok,
    input wire latch_ok,

    // drive commands
    output reg op_start,
    output reg [3:0] op_code,
    output reg [9:0] op_cyl,
    output reg [7:0] op_head,
    output reg [7:0] op_pattern,
    output reg [10:0] op_offset,
    output reg running,
    output reg error_led
);

// ----------------------------------------
// synchronisers, three stages
// ----------------------------------------
reg [61:0] s1, s2, s3, stable;
wire [61:0] raw_in = {drive_lines, index_pulse, on_track, op_done, op_error, cmp_ok, latch_ok};
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1 <= 62'h0;
        s2 <= 62'h0;
        s3 <= 62'h0;
        stable <= 62'h0;
    end else begin
        s1 <= raw_in;
        s2 <= s1;
        s3 <= s2;
        // a level counts once two stages agree; one-cycle glitches are dropped
        stable <= (s2 & s3) | (stable & (s2 | s3));
    end
end

wire [55:0] lines = stable[61:6];
wire idx = stable[5];
wire ontrk = stable[4];
wire done = stable[3];
wire err = stable[2];
wire cmp = stable[1];
wire lok = stable[0];
reg idx_d, done_d;
wire idx_rise = idx & ~idx_d;
wire done_rise = done & ~done_d;

// ----------------------------------------
// output bytes, bit 0 unused
// ----------------------------------------
wire [7:0] ob [0:6];
assign ob[0] = {lines[5:0], 2'h0} & 8'hfc; // RQ12
assign ob[1] = {lines[11:9], 1'b0, lines[8:6], 1'b0}; // RQ13
assign ob[2] = {lines[17:13], 1'b0, lines[12], 1'b0}; // RQ14
assign ob[3] = {lines[23], 1'b0, lines[22:19], 2'h0};
assign ob[4] = {lines[30:24], 1'b0}; // RQ15
assign ob[5] = {lines[37:31], 1'b0}; // RQ16
assign ob[6] = {lines[44:38], 1'b0}; // RQ17

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] routine, ectl, pptr, err_code, disp, outptr;
reg [7:0] pbyte [0:4];
reg pat_set, big_model, go;
reg [31:0] period;
wire wr = psel & penable & pwrite & pready;
wire rd_acc = psel & ~penable;
wire mapped = (paddr[11:6] == 6'h0) && (paddr[5:2] <= 4'h9) && (paddr[1:0] == 2'h0);
wire [9:0] cyl = {pbyte[0][1:0], pbyte[1]};
wire [9:0] cyl_max = big_model ? `DMDS_CYL_BIG : `DMDS_CYL_SMALL;

// ----------------------------------------
// engine states
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ISSUE = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_NEXT = 3'h3;
localparam ST_IDX = 3'h4;
localparam ST_STOP = 3'h5;

reg [2:0] state;
reg [15:0] reads;
reg [1:0] phase;
reg [31:0] cnt;
reg idx_seen;

// offset magnitude in microinches, sign in bit 10
// byte 04: bit 7 picks the direction, the low bits give the amount
wire [9:0] off_mag = {3'h0, pbyte[4][6:0]};
reg [9:0] off_acc;
wire fail = err | (op_code == 4'h1 && !cmp) | (op_code == 4'h3 && !lok)
    | (op_code == 4'h4 && ontrk);
wire [7:0] fail_code = err ? `DMDS_E_UNSAFE : (op_code == 4'h1) ? `DMDS_E_CMP
    : (op_code == 4'h3) ? `DMDS_E_LATCH : `DMDS_E_ONTRK;

// ----------------------------------------
// register bus and routine engine
// ----------------------------------------
integer k;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
        routine <= 8'h0;
        ectl <= `DMDS_EC_ONCE;
        pptr <= 8'h0;
        for (k = 0; k < 5; k = k + 1)
            pbyte[k] <= 8'h0;
        pat_set <= 1'b0;
        big_model <= 1'b1;
        go <= 1'b0;
        err_code <= `DMDS_E_NONE;
        disp <= 8'h0;
        outptr <= 8'h0;
        period <= 32'h0;
        state <= ST_IDLE;
        op_start <= 1'b0;
        op_code <= 4'h0;
        op_cyl <= 10'h0;
        op_head <= 8'h0;
        op_pattern <= `DMDS_PAT_DEF;
        op_offset <= 11'h0;
        running <= 1'b0;
        error_led <= 1'b0;
        reads <= 16'h0;
        phase <= 2'h0;
        cnt <= 32'h0;
        off_acc <= 10'h0;
        idx_seen <= 1'b0;
        idx_d <= 1'b0;
        done_d <= 1'b0;
    end else begin
        idx_d <= idx;
        done_d <= done;
        op_start <= 1'b0;
        go <= 1'b0;

        // apb: no wait state, ready in the first access cycle
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~mapped;
        if (rd_acc) begin
            case (paddr)
                `DMDS_CTRL: prdata <= {30'h0, big_model, 1'b0};
                `DMDS_ROUT: prdata <= {24'h0, routine};
                `DMDS_PPTR: prdata <= {24'h0, pptr};
                `DMDS_PDATA: prdata <= (pptr < 8'h5) ? {24'h0, pbyte[pptr[2:0]]} : 32'h0;
                `DMDS_ECTL: prdata <= {24'h0, ectl};
                `DMDS_STAT: prdata <= {29'h0, state};
                `DMDS_ERR: prdata <= {24'h0, err_code};
                `DMDS_DISP: prdata <= {16'h0, outptr, disp};
                `DMDS_PERIOD: prdata <= period;
                default: prdata <= 32'h0;
            endcase
        end
        if (wr && mapped) begin
            case (paddr)
                `DMDS_CTRL: begin
                    go <= pwdata[0];
                    big_model <= pwdata[1];
                    if (pwdata[2])
                        state <= ST_STOP;
                end
                `DMDS_ROUT: begin
                    routine <= pwdata[7:0];
                    pptr <= 8'h0; // RQ21
                    pat_set <= 1'b0;
                    ectl <= (pwdata[7:0] == `DMDS_R_READ) ? `DMDS_EC_CONT
                        : (pwdata[7:0] == `DMDS_R_SAFE || pwdata[7:0] == `DMDS_R_OFFS
                        || pwdata[7:0] == `DMDS_R_INDEX) ? `DMDS_EC_LINK : `DMDS_EC_ONCE;
                end
                `DMDS_PPTR: pptr <= pwdata[7:0];
                `DMDS_PDATA: begin
                    if (pptr < 8'h5)
                        pbyte[pptr[2:0]] <= pwdata[7:0];
                    if (pptr == 8'h3 && pwdata[7:0] != 8'h0)
                        pat_set <= 1'b1;
                    pptr <= pptr + 8'h1; // RQ21
                end
                `DMDS_ECTL: ectl <= pwdata[7:0];
                default: ;
            endcase
        end

        // a stop written while the engine moves on by itself is lost; repeat it
        case (state)
            ST_IDLE: begin
                if (go) begin
                    err_code <= `DMDS_E_NONE;
                    error_led <= 1'b0;
                    op_cyl <= cyl;
                    op_head <= pbyte[2];
                    op_pattern <= pat_set ? pbyte[3] : `DMDS_PAT_DEF; // RQ4
                    off_acc <= 10'h0;
                    reads <= 16'h0;
                    phase <= 2'h0;
                    if (routine == `DMDS_R_DISP) begin
                        // RQ11
                        if (pbyte[0] < {5'h0, `DMDS_NOUT} - 8'h1)
                            outptr <= pbyte[0] + 8'h1;
                        else if (pbyte[0] < {5'h0, `DMDS_NOUT})
                            outptr <= 8'h0;
                        else
                            outptr <= 8'h1;
                        disp <= ob[(pbyte[0] < {5'h0, `DMDS_NOUT}) ? pbyte[0][2:0] : 3'h0];
                    end else if (cyl > cyl_max && routine != `DMDS_R_RECAL
                        && routine != `DMDS_R_SAFE && routine != `DMDS_R_INDEX) begin
                        err_code <= `DMDS_E_CYL; // RQ5
                        error_led <= 1'b1;
                    end else if (routine == `DMDS_R_INDEX) begin
                        running <= 1'b1; // RQ10
                        cnt <= 32'h0;
                        idx_seen <= 1'b0;
                        state <= ST_IDX;
                    end else begin
                        running <= 1'b1;
                        state <= ST_ISSUE;
                    end
                end else if (routine == `DMDS_R_DISP && wr && paddr == `DMDS_DISP) begin
                    // RQ11
                    disp <= ob[outptr[2:0]];
                    outptr <= (outptr + 8'h1 >= {5'h0, `DMDS_NOUT}) ? 8'h0 : outptr + 8'h1;
                end
            end

            ST_ISSUE: begin
                op_start <= 1'b1;
                case (routine)
                    `DMDS_R_OFFRD: begin
                        op_code <= 4'h1; // RQ1
                        op_offset <= {1'b1, off_acc};
                    end

                    `DMDS_R_READ: begin
                        op_code <= 4'h1; // RQ7
                        op_offset <= {pbyte[4][7], (off_mag > `DMDS_OFF_MAX)
                            ? `DMDS_OFF_MAX : off_mag};
                    end
                    `DMDS_R_SAFE: op_code <= 4'h3; // RQ8

                    `DMDS_R_OFFS: begin
                        op_code <= 4'h4; // RQ9
                        op_offset <= {1'b0, `DMDS_OFF_STEP};
                    end

                    `DMDS_R_RECAL: begin
                        op_code <= 4'h5; // RQ18
                        op_cyl <= 10'h0;
                    end
                    `DMDS_R_WRITE: op_code <= 4'h2;
                    default: op_code <= 4'h0;
                endcase
                state <= ST_WAIT;
            end

            ST_WAIT: begin
                if (done_rise) begin
                    if (fail) begin
                        err_code <= fail_code; // RQ22
                        error_led <= 1'b1;
                        state <= (ectl == `DMDS_EC_LOOP) ? ST_ISSUE : ST_STOP;
                    end else
                        state <= ST_NEXT;
                end
            end

            ST_NEXT: begin
                state <= ST_STOP;
                case (routine)
                    `DMDS_R_OFFRD: begin
                        // RQ1 RQ2
                        if (off_acc + `DMDS_OFF_STEP <= `DMDS_OFF_END) begin
                            off_acc <= off_acc + `DMDS_OFF_STEP;
                            state <= ST_ISSUE;
                        end else if (ectl == `DMDS_EC_CONT || ectl == `DMDS_EC_LOOP) begin
                            off_acc <= 10'h0;
                            state <= ST_ISSUE;
                        end
                    end

                    `DMDS_R_READ: begin
                        reads <= reads + 16'h1; // RQ6
                        if (reads + 16'h1 < `DMDS_READS)
                            state <= ST_ISSUE;
                    end

                    `DMDS_R_SAFE: begin
                        phase <= phase + 2'h1; // RQ8
                        if (phase != 2'h3 || ectl == `DMDS_EC_LOOP)
                            state <= ST_ISSUE;
                    end

                    `DMDS_R_WRITE: begin
                        // RQ19 RQ20
                        if (!pbyte[4][7] && op_head < `DMDS_NHEADS) begin
                            op_head <= op_head + 8'h1;
                            state <= ST_ISSUE;
                        end else if (ectl == `DMDS_EC_CONT || ectl == `DMDS_EC_LOOP) begin
                            op_head <= pbyte[2];
                            state <= ST_ISSUE;
                        end
                    end

                    default: begin
                        if (ectl == `DMDS_EC_CONT)
                            state <= ST_ISSUE;
                    end
                endcase
            end

            ST_IDX: begin
                // RQ10: phase 0 on track, phase 1 with offset commanded
                cnt <= cnt + 32'h1;
                if (idx_rise) begin
                    // the rising edge is already the first cycle of the next period
                    cnt <= 32'h1;
                    idx_seen <= 1'b1;
                    if (idx_seen) begin
                        period <= cnt;
                        if (phase == 2'h0) begin
                            phase <= 2'h1;
                            idx_seen <= 1'b0;
                            op_code <= 4'h4;
                            op_offset <= {1'b0, `DMDS_OFF_STEP};
                            op_start <= 1'b1;
                        end else
                            state <= (ectl == `DMDS_EC_CONT) ? ST_IDX : ST_STOP;
                    end
                end else if (cnt >= IDX_TIMEOUT) begin
                    err_code <= `DMDS_E_INDEX; // RQ22
                    error_led <= 1'b1;
                    cnt <= 32'h0;
                    state <= (ectl == `DMDS_EC_LOOP) ? ST_IDX : ST_STOP;
                end
            end

            ST_STOP: begin
                running <= 1'b0;
                // heads come back on track once a routine ends
                op_offset <= 11'h0;
                state <= ST_IDLE;
            end

            default: state <= ST_IDLE;
        endcase
    end
end
endmodule // dmds_seq

// *** tb/dmds_seq_sva.sv ***
// assertion checker for the microdiagnostic sequencer ports
`timescale 1ns/100ps
module dmds_seq_sva (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    // drive link
    input wire op_start,
    input wire [3:0] op_code,
    input wire [9:0] op_cyl,
    input wire [7:0] op_pattern,
    input wire [10:0] op_offset
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
    property p_unmapped; psel && penable && pready && paddr > 12'h024 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    // ----------------------------------------
    // command link
    // ----------------------------------------
    property p_start_pulse; op_start |=> !op_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
    // the sync delay alone keeps done away for three cycles
    property p_hold;
        op_start |=> ($stable(op_code) && $stable(op_cyl) && $stable(op_offset)) [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("command changed while pending");
    property p_cyl; op_start |-> op_cyl <= 10'h32e; endproperty
    a_cyl: assert property (p_cyl) else $error("cylinder above limit");
    property p_off_max; op_start && op_code == 4'h1 |-> op_offset[9:0] <= 10'h307; endproperty
    a_off_max: assert property (p_off_max) else $error("offset too large");
    property p_pat; op_start && op_code == 4'h2 |-> op_pattern != 8'h00; endproperty
    a_pat: assert property (p_pat) else $error("empty write pattern");
    c_read: cover property (op_start && op_code == 4'h1);
    c_write: cover property (op_start && op_code == 4'h2);
    c_refuse: cover property (pready && pslverr);
endmodule // dmds_seq_sva
bind dmds_seq dmds_seq_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .op_start(op_start), .op_code(op_code), .op_cyl(op_cyl),
    .op_pattern(op_pattern), .op_offset(op_offset));

// *** tb/dmds_drive_model.sv ***
// behavioural drive answering the sequencer's commands
`timescale 1ns/100ps
module dmds_drive_model (
    // command side
    input wire pclk,
    input wire op_start,
    input wire [3:0] op_code,
    input wire [7:0] dly,
    input wire cmp_bad,
    // status side
    output reg op_done,
    output wire op_error,
    output wire cmp_ok,
    output wire latch_ok,
    output wire on_track,
    output reg index_pulse
);
    reg [5:0] idx_cnt = 6'h00;
    assign op_error = 1'b0;
    assign cmp_ok = !cmp_bad;
    assign latch_ok = 1'b1;
    assign on_track = (op_code != 4'h4);
    initial op_done = 1'b0;
    initial index_pulse = 1'b0;
    always @(posedge pclk) begin
        idx_cnt <= idx_cnt + 6'h01;
        // held four cycles: the three-stage input filter drops one-cycle pulses
        index_pulse <= (idx_cnt < 6'h04);
    end
    // done must fall again: the sequencer acts on its rising edge
    always @(posedge pclk)
        if (op_start) begin
            repeat (dly) @(posedge pclk);
            op_done <= 1'b1;
            repeat (2) @(posedge pclk);
            op_done <= 1'b0;
        end
endmodule // dmds_drive_model

// *** tb/dmds_seq_tb_top.sv ***
// self-checking bench of the microdiagnostic sequencer
`timescale 1ns/100ps
`include "dmds_map.vh"
module dmds_seq_tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [55:0] drive_lines = 56'h0;
    reg cmp_bad = 1'b0;
    reg [7:0] dly = 8'h03;
    wire [31:0] prdata;
    wire pready, pslverr, op_start, op_done, op_error, cmp_ok, latch_ok;
    wire on_track, index_pulse, running, error_led;
    wire [3:0] op_code;
    wire [9:0] op_cyl;
    wire [7:0] op_head, op_pattern;
    wire [10:0] op_offset;
    integer err_count = 0, num_checks = 0, n_ops = 0;
    reg step_bad = 1'b0;
    reg serr;
    reg [31:0] rdata;
    reg [10:0] last_off;
    reg [9:0] last_cyl;
    reg [7:0] last_head, last_pat;
    reg [3:0] last_code;
    always #2 pclk = ~pclk;
    dmds_seq #(.IDX_TIMEOUT(32'd100)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drive_lines(drive_lines), .index_pulse(index_pulse), .on_track(on_track),
        .op_done(op_done), .op_error(op_error), .cmp_ok(cmp_ok), .latch_ok(latch_ok),
        .op_start(op_start), .op_code(op_code), .op_cyl(op_cyl), .op_head(op_head),
        .op_pattern(op_pattern), .op_offset(op_offset), .running(running),
        .error_led(error_led));
    dmds_drive_model u_drive (.pclk(pclk), .op_start(op_start), .op_code(op_code),
        .dly(dly), .cmp_bad(cmp_bad), .op_done(op_done), .op_error(op_error),
        .cmp_ok(cmp_ok), .latch_ok(latch_ok), .on_track(on_track),
        .index_pulse(index_pulse));
    always @(posedge pclk)
        if (op_start === 1'b1) begin
            if (op_code === 4'h1 && op_offset[9:0] !== 10'h019 * n_ops[9:0])
                step_bad <= 1'b1;
            n_ops <= n_ops + 1;
            last_off <= op_offset;
            last_cyl <= op_cyl;
            last_head <= op_head;
            last_pat <= op_pattern;
            last_code <= op_code;
        end
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("MISMATCH %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rdata = prdata;
            serr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task load(input [7:0] r, input [7:0] ec, input [39:0] b, input integer n);
        integer i;
        begin
            apb(1, `DMDS_ROUT, {24'h0, r});
            for (i = 0; i < n; i = i + 1)
                apb(1, `DMDS_PDATA, {24'h0, b[8*i +: 8]});
            apb(1, `DMDS_ECTL, {24'h0, ec});
        end
    endtask
    task go(input [31:0] ctl, input integer nx, input [7:0] ex);
        begin
            n_ops = 0;
            step_bad = 1'b0;
            apb(1, `DMDS_CTRL, ctl);
            // running rises one cycle after the go strobe is taken
            repeat (2) @(posedge pclk);
            while (running !== 1'b0)
                @(posedge pclk);
            chk("ops", nx, n_ops);
            apb(0, `DMDS_ERR, 0);
            chk("err", ex, rdata[7:0]);
        end
    endtask
    task t_display;
        integer i, j;
        reg [55:0] m;
        begin
            m = 56'hfe_fe_fe_bc_fa_ee_fc;
            drive_lines <= {56{1'b1}};
            load(`DMDS_R_DISP, 8'h00, 40'h06, 1);
            apb(0, `DMDS_PPTR, 0);
            chk("pptr", 1, rdata);
            go(32'h3, 0, 8'h00);
            // nine reads cross the wrap from byte 6 back to byte 0
            for (i = 0; i < 9; i = i + 1) begin
                j = (6 + i) % 7;
                apb(0, `DMDS_DISP, 0);
                chk("disp", m[8*j +: 8], rdata[7:0]);
                apb(1, `DMDS_DISP, 0);
            end
        end
    endtask
    task wr_case(input [7:0] opt, input integer nx, input [7:0] hx);
        begin
            load(`DMDS_R_WRITE, `DMDS_EC_ONCE, 40'h10_2e_03, 3);
            apb(1, `DMDS_PPTR, 32'h4);
            apb(1, `DMDS_PDATA, {24'h0, opt});
            go(32'h3, nx, 8'h00);
            chk("head", hx, last_head);
            chk("pat", 8'hdb, last_pat);
            chk("cyl", 10'h32e, last_cyl);
        end
    endtask
    initial begin
        #200000;
        err_count = err_count + 1;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("pat", 8'hdb, op_pattern);
        apb(0, 12'h028, 0);
        chk("slverr", 1, serr);
        t_display;
        load(`DMDS_R_OFFRD, `DMDS_EC_ONCE, 40'h5a_03_00_01, 4);
        go(32'h3, 13, 8'h00);
        chk("step", 0, step_bad);
        chk("off", 11'h52c, last_off);
        chk("pat", 8'h5a, last_pat);
        cmp_bad <= 1'b1;
        go(32'h3, 1, `DMDS_E_CMP);
        chk("led", 1, error_led);
        load(`DMDS_R_READ, `DMDS_EC_CONT, 40'h85_5a_02_2e_03, 5);
        go(32'h3, 1, `DMDS_E_CMP);
        chk("rdoff", 11'h405, last_off);
        cmp_bad <= 1'b0;
        load(`DMDS_R_OFFRD, `DMDS_EC_ONCE, 40'h2f_03, 2);
        go(32'h3, 0, `DMDS_E_CYL);
        load(`DMDS_R_OFFRD, `DMDS_EC_ONCE, 40'h9b_01, 2);
        go(32'h1, 0, `DMDS_E_CYL);
        dly <= 8'h14;
        wr_case(8'h80, 1, 8'h10);
        dly <= 8'h01;
        wr_case(8'h00, 3, 8'h12);
        load(`DMDS_R_RECAL, `DMDS_EC_ONCE, 40'h0, 0);
        go(32'h3, 1, 8'h00);
        chk("recal", 5, last_code);
        load(`DMDS_R_SAFE, `DMDS_EC_LINK, 40'h0, 0);
        go(32'h3, 4, 8'h00);
        chk("safe", 3, last_code);
        load(`DMDS_R_OFFS, `DMDS_EC_LINK, 40'h0, 0);
        go(32'h3, 1, 8'h00);
        chk("offs", 11'h019, last_off);
        load(`DMDS_R_INDEX, `DMDS_EC_LINK, 40'h0, 0);
        go(32'h3, 1, 8'h00);
        apb(0, `DMDS_PERIOD, 0);
        chk("period", 64, rdata);
        end_sim;
    end
endmodule // dmds_seq_tb_top
